// ===== slfg_pkg.sv
// constants and types shared by the slice look-up table block
// Function
// - each slice has two four-input tables, any boolean function of four inputs
// - wide multiplexers merge table outputs within the block and from a neighbour
// - tables of both pairs act as rom loaded at configuration
// - only the memory-capable pair offers storage and shift modes
// - a storage table holds sixteen one-bit locations addressed by its selects
// - dual-port option pairs two tables for one shared write path and two independent read paths
// - storage contents are preloaded during configuration
// - shift mode gives a sixteen-stage shifter, tap delay one to sixteen
// - four memory-capable tables chain for delays up to sixty-four
// - cascade shift input and output link shifters across block boundaries
// - block holds four slices in two column pairs
// - even column pair is memory-capable, odd column pair logic-only
package slfg_pkg;

    localparam int LUT_AW         = 4;
    localparam int LUT_DEPTH      = 16;
    localparam int NUM_SLICES     = 4;
    localparam int LUTS_PER_SLICE = 2;
    localparam int NUM_LUTS       = NUM_SLICES * LUTS_PER_SLICE;
    localparam int NUM_MEM_LUTS   = 4;
    localparam int CFG_IDX_W      = 3;
    localparam int WIDE_SEL_W     = 8;
    localparam int BUF_DEPTH      = 2;

    // output word field positions
    localparam int WORD_W   = 16;
    localparam int F5_POS   = 8;
    localparam int F6_POS   = 12;
    localparam int F7_POS   = 14;
    localparam int F8_POS   = 15;
    localparam int F6_SEL   = 4;
    localparam int F7_SEL   = 6;
    localparam int F8_SEL   = 7;

    localparam logic [LUT_DEPTH-1:0] LUT_INIT_RESET = 16'h0000;
    localparam logic [WORD_W-1:0]    WORD_RESET     = 16'h0000;

    typedef enum logic [3:0] {
        MODE_ROM   = 4'b0001,
        MODE_RAM   = 4'b0010,
        MODE_DPRAM = 4'b0100,
        MODE_SHIFT = 4'b1000
    } slfg_mode_t;

    function automatic logic lut_read(input logic [LUT_DEPTH-1:0] tbl,
                                      input logic [LUT_AW-1:0]    addr);
        lut_read = tbl[addr];
    endfunction

endpackage

// ===== slfg_lut16.sv
// one sixteen-entry table: rom, storage or shifter
`timescale 1ns/100ps
module slfg_lut16
    import slfg_pkg::*;
#(
    parameter bit MEM_CAPABLE = 1'b1
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 resetn_in,
    input  wire logic                 cfg_we_in,
    input  wire logic [LUT_DEPTH-1:0] cfg_init_in,
    input  wire slfg_mode_t           cfg_mode_in,
    input  wire logic [LUT_AW-1:0]    rd_addr_in,
    input  wire logic [LUT_AW-1:0]    wr_addr_in,
    input  wire logic                 wr_en_in,
    input  wire logic                 wr_data_in,
    input  wire logic                 shift_en_in,
    input  wire logic                 shift_din_in,
    output logic                      rd_data_out,
    output logic                      cascade_out,
    output logic [LUT_DEPTH-1:0]      contents_out,
    output slfg_mode_t                mode_out
);

    logic [LUT_DEPTH-1:0] mem_ff;
    slfg_mode_t           mode_ff;
    logic                 ram_wr;
    logic                 sh_wr;

    // logic-only tables ignore storage and shift requests entirely
    assign ram_wr = MEM_CAPABLE && wr_en_in
                    && (mode_ff == MODE_RAM || mode_ff == MODE_DPRAM);
    assign sh_wr  = MEM_CAPABLE && shift_en_in && (mode_ff == MODE_SHIFT);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            mode_ff <= MODE_ROM;
        end else if (cfg_we_in) begin
            mode_ff <= MEM_CAPABLE ? cfg_mode_in : MODE_ROM;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            mem_ff <= LUT_INIT_RESET;
        end else if (cfg_we_in) begin
            mem_ff <= cfg_init_in;
        end else if (sh_wr) begin
            mem_ff <= {mem_ff[LUT_DEPTH-2:0], shift_din_in};
        end else if (ram_wr) begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
    end

    // tap at address n delays by n+1 shifts
    assign rd_data_out  = lut_read(mem_ff, rd_addr_in);
    assign cascade_out  = mem_ff[LUT_DEPTH-1];
    assign contents_out = mem_ff;
    assign mode_out     = mode_ff;

    a_cfg_preload: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        cfg_we_in |=> mem_ff == $past(cfg_init_in))
        else $error("config preload not stored");

    a_rom_holds: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!cfg_we_in && mode_ff == MODE_ROM) |=> $stable(mem_ff))
        else $error("rom contents changed without configuration");

    a_ram_write_lands: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!cfg_we_in && ram_wr) |=> mem_ff[$past(wr_addr_in)] == $past(wr_data_in))
        else $error("storage write did not land");

    a_shift_moves: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!cfg_we_in && sh_wr) |=> mem_ff == {$past(mem_ff[LUT_DEPTH-2:0]),
                                              $past(shift_din_in)})
        else $error("shift did not advance one stage");

    a_logic_only_mode: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        !MEM_CAPABLE |-> mode_ff == MODE_ROM)
        else $error("logic-only table left rom mode");

endmodule

// ===== slfg_clb.sv
// logic block of four slices with wide muxes, storage, shifters and output buffer
`timescale 1ns/100ps
module slfg_clb
    import slfg_pkg::*;
(
    input  wire logic                         clk_sys_in,
    input  wire logic                         resetn_in,
    input  wire logic                         cfg_we_in,
    input  wire logic [CFG_IDX_W-1:0]         cfg_idx_in,
    input  wire logic [LUT_DEPTH-1:0]         cfg_init_in,
    input  wire slfg_mode_t                   cfg_mode_in,
    input  wire logic                         cfg_chain_in,
    input  wire logic [NUM_LUTS*LUT_AW-1:0]   table_select_inputs_in,
    input  wire logic [NUM_MEM_LUTS-1:0]      wr_en_in,
    input  wire logic [NUM_MEM_LUTS-1:0]      wr_data_in,
    input  wire logic [NUM_MEM_LUTS-1:0]      shift_en_in,
    input  wire logic                         cascade_shift_input_in,
    input  wire logic [WIDE_SEL_W-1:0]        wide_sel_in,
    input  wire logic                         neighbor_wide_in,
    input  wire logic                         step_valid_in,
    output logic                              step_ready_out,
    output logic                              out_valid_out,
    input  wire logic                         out_ready_in,
    output logic [WORD_W-1:0]                 out_word_out,
    output logic                              cascade_shift_output_out
);

    logic [LUT_AW-1:0]    rd_addr  [NUM_LUTS];
    logic [LUT_AW-1:0]    wr_addr  [NUM_LUTS];
    logic                 wr_en    [NUM_LUTS];
    logic                 wr_dat   [NUM_LUTS];
    logic                 sh_en    [NUM_LUTS];
    logic                 sh_din   [NUM_LUTS];
    logic [LUT_DEPTH-1:0] contents [NUM_LUTS];
    slfg_mode_t           lut_mode [NUM_LUTS];
    logic [NUM_LUTS-1:0]  lut_out;
    logic [NUM_LUTS-1:0]  lut_casc;
    logic [NUM_MEM_LUTS-1:0] chain_ff;
    logic [NUM_MEM_LUTS-1:0] shift_src;
    logic [NUM_SLICES-1:0]   f5;
    logic [1:0]              f6;
    logic                    f7;
    logic                    f8;
    logic [WORD_W-1:0]       word;
    logic                    accept;
    logic                    pop;
    logic [WORD_W-1:0]       buf_ff [BUF_DEPTH];
    logic                    wptr_ff;
    logic                    rptr_ff;
    logic [1:0]              cnt_ff;

    // a full buffer stalls the step, so no write or shift happens without its word
    assign accept         = step_valid_in && step_ready_out;
    assign pop            = out_valid_out && out_ready_in;
    assign step_ready_out = (cnt_ff != 2'(BUF_DEPTH));
    assign out_valid_out  = (cnt_ff != 2'd0);
    assign out_word_out   = buf_ff[rptr_ff];

    // stage k shifts from stage k-1, stage 0 from the cascade input
    assign shift_src = {lut_casc[NUM_MEM_LUTS-2:0], cascade_shift_input_in};
    assign cascade_shift_output_out = lut_casc[NUM_MEM_LUTS-1];

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            chain_ff <= '0;
        end else if (cfg_we_in && cfg_idx_in < CFG_IDX_W'(NUM_MEM_LUTS)) begin
            chain_ff[cfg_idx_in[1:0]] <= cfg_chain_in;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_LUTS; i++) begin
            rd_addr[i] = table_select_inputs_in[i*LUT_AW +: LUT_AW];
            wr_addr[i] = rd_addr[i];
            wr_en[i]   = 1'b0;
            wr_dat[i]  = 1'b0;
            sh_en[i]   = 1'b0;
            sh_din[i]  = 1'b0;
        end
        for (int m = 0; m < NUM_MEM_LUTS; m++) begin
            // odd table of a dual pair follows the even table's write port
            if (m[0] && lut_mode[m] == MODE_DPRAM) begin
                wr_addr[m] = rd_addr[m ^ 1];
                wr_en[m]   = accept && wr_en_in[m ^ 1];
                wr_dat[m]  = wr_data_in[m ^ 1];
            end else begin
                wr_en[m]   = accept && wr_en_in[m];
                wr_dat[m]  = wr_data_in[m];
            end
            sh_en[m]  = accept && shift_en_in[m];
            sh_din[m] = chain_ff[m] ? shift_src[m] : wr_data_in[m];
        end
    end

    // tables 0-3 form slices 0-1 (even column), tables 4-7 slices 2-3 (odd column)
    for (genvar i = 0; i < NUM_LUTS; i++) begin : g_lut
        slfg_lut16 #(
            .MEM_CAPABLE (i < NUM_MEM_LUTS)
        ) u_lut (
            .clk_sys_in   (clk_sys_in),
            .resetn_in    (resetn_in),
            .cfg_we_in    (cfg_we_in && cfg_idx_in == CFG_IDX_W'(i)),
            .cfg_init_in  (cfg_init_in),
            .cfg_mode_in  (cfg_mode_in),
            .rd_addr_in   (rd_addr[i]),
            .wr_addr_in   (wr_addr[i]),
            .wr_en_in     (wr_en[i]),
            .wr_data_in   (wr_dat[i]),
            .shift_en_in  (sh_en[i]),
            .shift_din_in (sh_din[i]),
            .rd_data_out  (lut_out[i]),
            .cascade_out  (lut_casc[i]),
            .contents_out (contents[i]),
            .mode_out     (lut_mode[i])
        );
    end

    always_comb begin
        for (int s = 0; s < NUM_SLICES; s++) begin
            f5[s] = wide_sel_in[s] ? lut_out[2*s+1] : lut_out[2*s];
        end
        for (int p = 0; p < 2; p++) begin
            f6[p] = wide_sel_in[F6_SEL+p] ? f5[2*p+1] : f5[2*p];
        end
        f7 = wide_sel_in[F7_SEL] ? f6[1] : f6[0];
        f8 = wide_sel_in[F8_SEL] ? neighbor_wide_in : f7;
    end

    assign word = {f8, f7, f6, f5, lut_out};

    // two-entry buffer: the word read before the edge is the word pushed
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            buf_ff[0] <= WORD_RESET;
            buf_ff[1] <= WORD_RESET;
        end else if (accept) begin
            buf_ff[wptr_ff] <= word;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            wptr_ff <= 1'b0;
            rptr_ff <= 1'b0;
            cnt_ff  <= 2'd0;
        end else begin
            if (accept) begin
                wptr_ff <= ~wptr_ff;
            end
            if (pop) begin
                rptr_ff <= ~rptr_ff;
            end
            cnt_ff <= cnt_ff + 2'(accept) - 2'(pop);
        end
    end

    // a refused step must leave storage, shifters and the buffer untouched
    a_buf_stall_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (out_valid_out && !out_ready_in) |=> out_valid_out && $stable(out_word_out))
        else $error("stalled word lost or changed");

    a_buf_no_overfill: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (cnt_ff == 2'd2) |-> !step_ready_out ##1 (cnt_ff != 2'd3))
        else $error("buffer accepted past full");

    a_push_fills_buf: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (accept && !pop && cnt_ff == 2'd1) |=> !step_ready_out)
        else $error("buffer not full after second word");

    a_pop_keeps_next: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (pop && !accept && cnt_ff == 2'd2) |=> out_valid_out)
        else $error("second word lost on pop");

    a_last_pop_empties: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (pop && !accept && cnt_ff == 2'd1) |=> !out_valid_out)
        else $error("valid held after last word left");

    a_word_carries_f7: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (accept && cnt_ff == 2'd0) |=> out_word_out[F7_POS] == $past(f7)
                                       && out_word_out[F5_POS] == $past(f5[0]))
        else $error("wide mux result not delivered");

    a_f8_from_neighbor: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (accept && cnt_ff == 2'd0 && wide_sel_in[F8_SEL])
        |=> out_word_out[F8_POS] == $past(neighbor_wide_in))
        else $error("neighbour wide input not delivered");

    a_dual_mirror: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (accept && wr_en_in[2] && !cfg_we_in && lut_mode[2] == MODE_DPRAM
         && lut_mode[3] == MODE_DPRAM)
        |=> contents[3][$past(rd_addr[2])] == $past(wr_data_in[2])
            && contents[2][$past(rd_addr[2])] == $past(wr_data_in[2]))
        else $error("dual pair copies differ after write");

    a_chain_entry_stage: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (accept && !cfg_we_in && shift_en_in[0] && chain_ff[0]
         && lut_mode[0] == MODE_SHIFT)
        |=> contents[0][0] == $past(cascade_shift_input_in))
        else $error("cascade input not taken by first stage");

    a_cascade_link: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (accept && !cfg_we_in && shift_en_in[1] && chain_ff[1]
         && lut_mode[1] == MODE_SHIFT)
        |=> contents[1][0] == $past(contents[0][LUT_DEPTH-1]))
        else $error("cascade did not carry last stage");

    a_stall_blocks_write: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!step_ready_out && !cfg_we_in && lut_mode[1] == MODE_RAM)
        |=> $stable(contents[1]))
        else $error("storage changed while step stalled");

    a_odd_pair_rom: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        lut_mode[NUM_LUTS-1] == MODE_ROM && lut_mode[NUM_MEM_LUTS] == MODE_ROM)
        else $error("odd column table left rom mode");

    c_buffer_full: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
        cnt_ff == 2'd2 && step_valid_in);
    c_stall_write: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
        !step_ready_out && step_valid_in && wr_en_in[1]);
    c_dual_write: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
        accept && wr_en_in[2] && lut_mode[3] == MODE_DPRAM);
    c_chain_shift: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
        accept && shift_en_in[3] && chain_ff[3] && lut_mode[3] == MODE_SHIFT);
    c_neighbor_wide: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
        accept && wide_sel_in[F8_SEL]);

endmodule

// ===== slfg_rx_model.sv
// receiver model taking words from the block output stream
`timescale 1ns/100ps
module slfg_rx_model (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        stall_in,
    input  wire logic        valid_in,
    input  wire logic [15:0] word_in,
    output logic             ready_out,
    output logic             take_out,
    output logic [15:0]      word_out
);
    logic        ready_ff;
    logic        take_ff;
    logic [15:0] word_ff;
    // ready only moves after an edge, as registered user logic would
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ready_ff <= 1'b0;
            take_ff  <= 1'b0;
            word_ff  <= 16'h0000;
        end else begin
            ready_ff <= !stall_in;
            take_ff  <= valid_in && ready_ff;
            word_ff  <= word_in;
        end
    end
    assign ready_out = ready_ff;
    assign take_out  = take_ff;
    assign word_out  = word_ff;
endmodule

// ===== tb_top.sv
// self-checking bench for the slice look-up table block
`timescale 1ns/100ps
module tb_top
    import slfg_pkg::*;
();
    localparam logic [15:0] PAT   = 16'hA5C3;
    localparam logic [15:0] INIT1 = 16'h0F0F;
    localparam logic [15:0] DP    = 16'h3C96;
    logic        clk;
    logic        resetn;
    logic        cfg_we;
    logic        cfg_ch;
    logic [2:0]  cfg_idx;
    logic [15:0] cfg_v;
    slfg_mode_t  cfg_m;
    logic [31:0] sel;
    logic [3:0]  wen;
    logic [3:0]  wdat;
    logic [3:0]  sen;
    logic [7:0]  wsel;
    logic        sv;
    logic        cin;
    logic        nb;
    logic        stall;
    logic        ready;
    logic        ovalid;
    logic        oready;
    logic        cout;
    logic        take;
    logic [15:0] oword;
    logic [15:0] rword;
    logic [15:0] rxq [$];
    int          err_total;
    int          tests_run;
    int          cyc;
    logic [15:0] rom_v [8] = '{16'h6996, 16'h8001, 16'hF00F, 16'h3C5A,
                               16'h00FF, 16'hA5A5, 16'h1E87, 16'hC3D2};

    slfg_clb uut (.clk_sys_in(clk), .resetn_in(resetn), .cfg_we_in(cfg_we),
        .cfg_idx_in(cfg_idx), .cfg_init_in(cfg_v), .cfg_mode_in(cfg_m),
        .cfg_chain_in(cfg_ch), .table_select_inputs_in(sel), .wr_en_in(wen),
        .wr_data_in(wdat), .shift_en_in(sen), .cascade_shift_input_in(cin),
        .wide_sel_in(wsel), .neighbor_wide_in(nb), .step_valid_in(sv),
        .step_ready_out(ready), .out_valid_out(ovalid), .out_ready_in(oready),
        .out_word_out(oword), .cascade_shift_output_out(cout));
    slfg_rx_model rx (.clk_in(clk), .resetn_in(resetn), .stall_in(stall),
        .valid_in(ovalid), .word_in(oword), .ready_out(oready),
        .take_out(take), .word_out(rword));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (take === 1'b1)
            rxq.push_back(rword);
    end
    // whole run needs a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk_bit(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] exp_word(input logic [3:0] a, input logic [7:0] ws,
                                             input logic n);
        logic [7:0] t;
        logic [3:0] f5;
        logic [1:0] f6;
        logic       f7;
        for (int i = 0; i < 8; i++)
            t[i] = rom_v[i][a];
        for (int s = 0; s < 4; s++)
            f5[s] = ws[s] ? t[2*s+1] : t[2*s];
        for (int p = 0; p < 2; p++)
            f6[p] = ws[4+p] ? f5[2*p+1] : f5[2*p];
        f7 = ws[6] ? f6[1] : f6[0];
        return {ws[7] ? n : f7, f7, f6, f5, t};
    endfunction
    // a lowered strobe is left for a full cycle before the next call raises it
    task automatic cfg(input logic [2:0] i, input logic [15:0] v, input slfg_mode_t m,
                       input logic ch);
        cfg_we <= 1'b1;
        cfg_idx <= i;
        cfg_v <= v;
        cfg_m <= m;
        cfg_ch <= ch;
        @(posedge clk);
        cfg_we <= 1'b0;
        @(posedge clk);
    endtask
    // inputs stay put until the accept edge and after it
    task automatic step(input logic [31:0] s, input logic [3:0] we, input logic [3:0] wd,
                        input logic [3:0] se, output logic [15:0] w);
        int n;
        n = 0;
        sel <= s;
        wen <= we;
        wdat <= wd;
        sen <= se;
        sv <= 1'b1;
        @(posedge clk);
        while (ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        sv <= 1'b0;
        while (rxq.size() == 0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        w = (rxq.size() > 0) ? rxq.pop_front() : 16'hxxxx;
    endtask

    task automatic t_wide();
        logic [15:0] w;
        // logic-only tables are asked for shift mode and must stay rom
        for (int i = 0; i < 8; i++)
            cfg(3'(i), rom_v[i], (i < 4) ? MODE_ROM : MODE_SHIFT, 1'b0);
        for (int a = 0; a < 16; a++) begin
            wsel <= 8'(a * 45);
            nb <= a[0];
            step({8{a[3:0]}}, 4'h0, 4'h0, 4'h0, w);
            chk_word(w, exp_word(a[3:0], 8'(a * 45), a[0]));
        end
        $display("wide and rom test done");
    endtask
    task automatic t_mem();
        logic [15:0] w;
        logic [3:0]  b;
        cfg(3'd1, INIT1, MODE_RAM, 1'b0);
        cfg(3'd2, 16'h0000, MODE_DPRAM, 1'b0);
        cfg(3'd3, 16'hFFFF, MODE_DPRAM, 1'b0);
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 16; a++) begin
                b = 4'(15 - a);
                step({16'h0000, b, a[3:0], a[3:0], 4'h0}, p ? 4'h0 : 4'h6,
                     {1'b0, DP[a], PAT[a], 1'b0}, 4'h0, w);
                chk_bit(w[1], p ? PAT[a] : INIT1[a]);
                chk_bit(w[2], p ? DP[a] : 1'b0);
                if (p == 1)
                    chk_bit(w[3], DP[b]);
            end
        end
        $display("storage test done");
    endtask
    task automatic t_full();
        logic [15:0] w;
        int          n;
        n = 0;
        stall <= 1'b1;
        @(posedge clk);
        sel <= {8{4'h0}};
        sv <= 1'b1;
        @(posedge clk);
        sel <= {8{4'h1}};
        @(posedge clk);
        sel <= {8{4'h2}};
        wen <= 4'h2;
        wdat <= 4'h2;
        repeat (4) begin
            @(posedge clk);
            chk_bit(ready, 1'b0);
            chk_bit(ovalid, 1'b1);
        end
        stall <= 1'b0;
        @(posedge clk);
        while (ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        sv <= 1'b0;
        wen <= 4'h0;
        repeat (8) @(posedge clk);
        // a write slipping in while refused would show in the third word
        for (int p = 0; p < 3; p++) begin
            w = (rxq.size() > 0) ? rxq.pop_front() : 16'hxxxx;
            chk_bit(w[1], PAT[p]);
        end
        step({8{4'h2}}, 4'h0, 4'h0, 4'h0, w);
        chk_bit(w[1], 1'b1);
        $display("full buffer test done");
    endtask
    task automatic t_shift();
        logic [15:0] w;
        logic        d [0:79];
        logic [3:0]  n0;
        logic [3:0]  n3;
        for (int i = 0; i < 4; i++)
            cfg(3'(i), 16'h0000, MODE_SHIFT, 1'b1);
        for (int k = 0; k < 72; k++) begin
            d[k] = PAT[k % 16] ^ k[4];
            n0 = 4'(k);
            n3 = 4'(k * 5);
            cin <= d[k];
            step({16'h0000, n3, 8'h00, n0}, 4'h0, 4'h0, 4'hF, w);
            chk_bit(w[0], (k > n0) ? d[k-1-n0] : 1'b0);
            chk_bit(w[3], (k > 48 + n3) ? d[k-49-n3] : 1'b0);
            chk_bit(cout, (k >= 63) ? d[k-63] : 1'b0);
        end
        $display("shift chain test done");
    endtask

    initial begin
        {resetn, cfg_we, cfg_ch, sv, cin, nb, stall} <= 7'h00;
        {cfg_idx, cfg_v, sel, wen, wdat, sen, wsel} <= 71'h0;
        cfg_m <= MODE_ROM;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk_word(oword, 16'h0000);
        chk_bit(ready, 1'b1);
        t_wide();
        t_mem();
        t_full();
        t_shift();
        give_verdict();
    end
endmodule
